// file: include/lcs_cfg_if.sv
// carrier between configuration front end and register slice
// assumes one clock domain; access_valid is a one-cycle pulse
`timescale 1ns/10ps
interface lcs_cfg_if;
  logic access_valid;
  logic access_write;
  logic [5:0] access_dword;
  logic [3:0] access_byte_en;
  logic [31:0] access_wdata;
  logic [31:0] access_rdata;

  modport front (
    output access_valid,
    output access_write,
    output access_dword,
    output access_byte_en,
    output access_wdata,
    input access_rdata
  );

  modport regs (
    input access_valid,
    input access_write,
    input access_dword,
    input access_byte_en,
    input access_wdata,
    output access_rdata
  );
endinterface

// file: include/lcs_pkg.sv
// package of constants for the link control / status / pm header slice
// assumes byte-addressed configuration accesses of one dword at a time
//
// Behaviour
// - link control bit 6 is a writable common-clock flag, cleared at reset.
// - reported idle exit latency is derived from the common-clock flag.
// - latency reads 110b with flag 0, 010b with flag 1, following rewrites.
// - link control bits 1:0 hold a two-bit power control field, reset zero.
// - power control field is stored and read back but steers nothing.
// - link control bit 3 always reads zero.
// - link control bits 15:7, 5:4, 2 read zero; whole word resets to zero.
// - link status bits 9:4 report negotiated lane width, read-only.
// - link status bits 3:0 report fixed speed code 0001b.
// - link status is read-only, 15:10 zero, value tracks width plus speed.
// - capability identifier byte reads 01h, read-only.
// - next capability pointer byte reads zero, read-only.
package lcs_pkg;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] LCS_OFF_LINK_CAPABILITIES = 8'h50;
  localparam logic [7:0] LCS_OFF_LINK_CONTROL = 8'h54;
  localparam logic [7:0] LCS_OFF_LINK_STATUS = 8'h56;
  localparam logic [7:0] LCS_OFF_PM_CAPABILITY_IDENTIFIER = 8'h6c;
  localparam logic [7:0] LCS_OFF_PM_NEXT_PTR = 8'h6d;
  localparam int LCS_DWORD_LSB = 2;

  // ************************************************************
  // link control fields
  // ************************************************************
  localparam int LCS_CCF_BIT = 6;
  localparam int LCS_ASPM_LSB = 0;
  localparam int LCS_ASPM_MSB = 1;
  localparam int LCS_RRRP_BIT = 3;
  localparam logic [15:0] LCS_LINK_CONTROL_RESET = 16'h0000;
  localparam logic [1:0] LCS_ASPM_DISABLED = 2'h0;
  localparam logic [1:0] LCS_ASPM_LOW_IDLE = 2'h1;
  localparam logic [1:0] LCS_ASPM_RESERVED = 2'h2;
  localparam logic [1:0] LCS_ASPM_BOTH_IDLE = 2'h3;

  // ************************************************************
  // link status fields
  // ************************************************************
  localparam int LCS_WIDTH_LSB = 4;
  localparam int LCS_WIDTH_MSB = 9;
  localparam int LCS_SPEED_LSB = 0;
  localparam int LCS_SPEED_MSB = 3;
  localparam logic [3:0] LCS_SPEED_2G5 = 4'h1;
  localparam logic [5:0] LCS_WIDTH_X1 = 6'h00;
  localparam logic [5:0] LCS_WIDTH_X4 = 6'h04;
  localparam logic [5:0] LCS_WIDTH_X8 = 6'h08;

  // ************************************************************
  // link capabilities: fixed part and exit latency field
  // ************************************************************
  localparam logic [31:0] LCS_LINK_CAP_FIXED = 32'h0003_8081;
  localparam int LCS_EXIT_LAT_LSB = 12;
  localparam int LCS_EXIT_LAT_MSB = 14;
  localparam logic [2:0] LCS_EXIT_LAT_ASYNC = 3'h6;
  localparam logic [2:0] LCS_EXIT_LAT_COMMON = 3'h2;

  // ************************************************************
  // power management header
  // ************************************************************
  localparam logic [7:0] LCS_PM_CAPABILITY_IDENTIFIER_VALUE = 8'h01;
  localparam logic [7:0] LCS_PM_NEXT_PTR_VALUE = 8'h00;

  localparam logic [31:0] LCS_READ_ZERO = 32'h0000_0000;

  // ************************************************************
  // functions
  // ************************************************************
  // dword index of a byte address
  function automatic logic [5:0] dword_of(input logic [7:0] byte_addr);
    dword_of = byte_addr[7:LCS_DWORD_LSB];
  endfunction

  // exit latency code for a given common-clock setting
  function automatic logic [2:0] exit_latency(input logic common_clock);
    exit_latency = common_clock ? LCS_EXIT_LAT_COMMON : LCS_EXIT_LAT_ASYNC;
  endfunction

endpackage

// file: logic/lcs_cfg_front.sv
// configuration access front end: takes a request, issues one access
// assumes requester holds cfg_valid until cfg_ready is seen high
`timescale 1ns/10ps
module lcs_cfg_front (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ready,
  output logic cfg_done,
  output logic [31:0] cfg_rdata,
  lcs_cfg_if.front acc
);

  typedef enum logic [1:0] {
    LCS_ST_IDLE,
    LCS_ST_ACCESS
  } lcs_state_e;

  lcs_state_e state;
  logic req_write;
  logic [5:0] req_dword;
  logic [3:0] req_byte_en;
  logic [31:0] req_wdata;

  // ************************************************************
  // request sequencing
  // ************************************************************
  assign cfg_ready = (state == LCS_ST_IDLE);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= LCS_ST_IDLE;
    end else begin
      unique case (state)
        LCS_ST_IDLE: begin
          if (cfg_valid) begin
            state <= LCS_ST_ACCESS;
          end
        end
        LCS_ST_ACCESS: begin
          state <= LCS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      req_write <= 1'b0;
      req_dword <= 6'h00;
      req_byte_en <= 4'h0;
      req_wdata <= 32'h0000_0000;
    end else if (cfg_valid && cfg_ready) begin
      req_write <= cfg_write;
      req_dword <= lcs_pkg::dword_of(cfg_addr);
      req_byte_en <= cfg_byte_en;
      req_wdata <= cfg_wdata;
    end
  end

  // ************************************************************
  // access to the register slice
  // ************************************************************
  assign acc.access_valid = (state == LCS_ST_ACCESS);
  assign acc.access_write = req_write;
  assign acc.access_dword = req_dword;
  assign acc.access_byte_en = req_byte_en;
  assign acc.access_wdata = req_wdata;

  // ************************************************************
  // completion
  // ************************************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_done <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_done <= acc.access_valid;
      if (acc.access_valid) begin
        cfg_rdata <= req_write ? lcs_pkg::LCS_READ_ZERO : acc.access_rdata;
      end
    end
  end

endmodule

// file: logic/lcs_link_regs.sv
// link control, link status and power management header registers
// assumes configuration requests on the core clock; lane width
// arrives from the link layer asynchronously and is synchronised here
`timescale 1ns/10ps
module lcs_link_regs (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ready,
  output logic cfg_done,
  output logic [31:0] cfg_rdata,
  input wire logic [5:0] link_width_raw,
  output logic common_clock_flag,
  output logic [2:0] idle_exit_latency,
  output logic [5:0] negotiated_lane_width
);

  lcs_cfg_if acc ();

  // ************************************************************
  // stored state
  // ************************************************************
  logic [1:0] active_state_pm_control;
  logic [5:0] width_meta;

  // ************************************************************
  // decoded access
  // ************************************************************
  logic hit_link_cap;
  logic hit_link_ctrl;
  logic hit_pm_header;
  logic ctrl_byte_write;

  // ************************************************************
  // read images
  // ************************************************************
  logic [15:0] link_control;
  logic [15:0] link_status;
  logic [31:0] link_capabilities;
  logic [7:0] power_capability_identifier;
  logic [7:0] power_capability_next_pointer;
  logic [31:0] next_rdata;

  // ************************************************************
  // configuration front end
  // ************************************************************
  lcs_cfg_front u_front (
    .clock(clock),
    .reset_n(reset_n),
    .cfg_valid(cfg_valid),
    .cfg_write(cfg_write),
    .cfg_addr(cfg_addr),
    .cfg_byte_en(cfg_byte_en),
    .cfg_wdata(cfg_wdata),
    .cfg_ready(cfg_ready),
    .cfg_done(cfg_done),
    .cfg_rdata(cfg_rdata),
    .acc(acc.front)
  );

  // ************************************************************
  // address decode
  // ************************************************************
  assign hit_link_cap =
    (acc.access_dword == lcs_pkg::dword_of(lcs_pkg::LCS_OFF_LINK_CAPABILITIES));

  assign hit_link_ctrl =
    (acc.access_dword == lcs_pkg::dword_of(lcs_pkg::LCS_OFF_LINK_CONTROL));

  assign hit_pm_header =
    (acc.access_dword == lcs_pkg::dword_of(lcs_pkg::LCS_OFF_PM_CAPABILITY_IDENTIFIER));

  // byte lane mask
  // only the low control byte holds writable bits; the other lanes
  // of that dword and every other dword accept writes and discard them
  assign ctrl_byte_write = acc.access_valid
    && acc.access_write
    && hit_link_ctrl
    && acc.access_byte_en[0];

  // ************************************************************
  // lane width synchroniser
  // ************************************************************
  // two stages; only the second stage feeds any logic
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      width_meta <= lcs_pkg::LCS_WIDTH_X1;
    end else begin
      width_meta <= link_width_raw;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      negotiated_lane_width <= lcs_pkg::LCS_WIDTH_X1;
    end else begin
      negotiated_lane_width <= width_meta;
    end
  end

  // ************************************************************
  // common clock flag
  // ************************************************************
  // writable clock flag
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      common_clock_flag <= lcs_pkg::LCS_LINK_CONTROL_RESET[lcs_pkg::LCS_CCF_BIT];
    end else if (ctrl_byte_write) begin
      common_clock_flag <= acc.access_wdata[lcs_pkg::LCS_CCF_BIT];
    end
  end

  // ************************************************************
  // active state power management control
  // ************************************************************
  // stored pm field
  // all four codes are kept as written, the reserved one included
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      active_state_pm_control <=
        lcs_pkg::LCS_LINK_CONTROL_RESET[lcs_pkg::LCS_ASPM_MSB:lcs_pkg::LCS_ASPM_LSB];
    end else if (ctrl_byte_write) begin
      active_state_pm_control <=
        acc.access_wdata[lcs_pkg::LCS_ASPM_MSB:lcs_pkg::LCS_ASPM_LSB];
    end
  end

  // readback only
  // the field drives no idle entry logic; it only reappears on reads

  // ************************************************************
  // idle exit latency
  // ************************************************************
  // latency from flag
  // latency codes
  // decoded straight from the flag flop, so it follows each rewrite
  // from the cycle after the write
  assign idle_exit_latency = lcs_pkg::exit_latency(common_clock_flag);

  // ************************************************************
  // link control read image
  // ************************************************************
  always_comb begin
    link_control = lcs_pkg::LCS_LINK_CONTROL_RESET;
    link_control[lcs_pkg::LCS_CCF_BIT] = common_clock_flag;
    link_control[lcs_pkg::LCS_ASPM_MSB:lcs_pkg::LCS_ASPM_LSB] =
      active_state_pm_control;
    link_control[lcs_pkg::LCS_RRRP_BIT] = 1'b0;
  end

  // ************************************************************
  // link status read image
  // ************************************************************
  always_comb begin
    link_status = 16'h0000;
    link_status[lcs_pkg::LCS_WIDTH_MSB:lcs_pkg::LCS_WIDTH_LSB] =
      negotiated_lane_width;
    link_status[lcs_pkg::LCS_SPEED_MSB:lcs_pkg::LCS_SPEED_LSB] =
      lcs_pkg::LCS_SPEED_2G5;
  end

  // ************************************************************
  // link capabilities read image
  // ************************************************************
  always_comb begin
    link_capabilities = lcs_pkg::LCS_LINK_CAP_FIXED;
    link_capabilities[lcs_pkg::LCS_EXIT_LAT_MSB:lcs_pkg::LCS_EXIT_LAT_LSB] =
      idle_exit_latency;
  end

  // ************************************************************
  // power management header
  // ************************************************************
  // capability identifier
  assign power_capability_identifier = lcs_pkg::LCS_PM_CAPABILITY_IDENTIFIER_VALUE;

  assign power_capability_next_pointer = lcs_pkg::LCS_PM_NEXT_PTR_VALUE;

  // ************************************************************
  // read data
  // ************************************************************
  // all lanes of a hit dword are returned; the requester picks its
  // bytes. unmapped dwords read as zero
  always_comb begin
    next_rdata = lcs_pkg::LCS_READ_ZERO;
    if (hit_link_cap) begin
      next_rdata = link_capabilities;
    end else if (hit_link_ctrl) begin
      next_rdata = {link_status, link_control};
    end else if (hit_pm_header) begin
      next_rdata[15:0] = {power_capability_next_pointer, power_capability_identifier};
    end
  end

  assign acc.access_rdata = next_rdata;

endmodule

// file: tb/lcs_link_regs_asserts.sv
// port checker for the link register slice
// assumes a bind onto lcs_link_regs, one core clock
`timescale 1ns/10ps
module lcs_link_regs_asserts (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_ready,
  input wire logic cfg_done,
  input wire logic [31:0] cfg_rdata,
  input wire logic [5:0] link_width_raw,
  input wire logic common_clock_flag,
  input wire logic [2:0] idle_exit_latency,
  input wire logic [5:0] negotiated_lane_width
);
  logic lat_w;
  logic lat_be;
  logic lat_d;
  logic [5:0] lat_a;
  logic rd_ctl;
  logic wr_ctl;
  // ********************
  // taken request capture
  // ********************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lat_w <= 1'b0;
      lat_be <= 1'b0;
      lat_d <= 1'b0;
      lat_a <= 6'h00;
    end else if (cfg_valid && cfg_ready) begin
      lat_w <= cfg_write;
      lat_be <= cfg_byte_en[0];
      lat_d <= cfg_wdata[6];
      lat_a <= cfg_addr[7:2];
    end
  end
  assign rd_ctl = cfg_done && !lat_w && lat_a == 6'h15;
  assign wr_ctl = cfg_done && lat_w && lat_be && lat_a == 6'h15;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_take_done: assert property (
    cfg_valid && cfg_ready |=> !cfg_ready ##1 cfg_done)
    else $error("access did not complete in two cycles");
  chk_done_cause: assert property (
    cfg_done |-> $past(cfg_valid && cfg_ready, 2))
    else $error("completion without a taken request");
  chk_lat_map: assert property (
    idle_exit_latency == (common_clock_flag ? 3'h2 : 3'h6))
    else $error("exit latency code wrong");
  chk_lat_follow: assert property (
    $changed(common_clock_flag) |-> $changed(idle_exit_latency))
    else $error("exit latency did not follow flag");
  chk_flag_source: assert property (
    $changed(common_clock_flag) |-> wr_ctl)
    else $error("flag changed without a write");
  chk_flag_write: assert property (
    wr_ctl |=> common_clock_flag == $past(lat_d))
    else $error("flag not stored from write");
  chk_ctl_fixed: assert property (
    rd_ctl |-> cfg_rdata[31:26] == 6'h00 && cfg_rdata[19:16] == 4'h1 && cfg_rdata[15:7] == 9'h000
      && cfg_rdata[5:2] == 4'h0)
    else $error("fixed control or status bits wrong");
  chk_ctl_live: assert property (
    rd_ctl |-> cfg_rdata[6] == common_clock_flag && cfg_rdata[25:20] == $past(negotiated_lane_width))
    else $error("flag or width read back wrong");
  chk_wr_zero: assert property (
    cfg_done && lat_w |-> cfg_rdata == 32'h0000_0000)
    else $error("write returned data");
  chk_cap_hdr: assert property (
    cfg_done && !lat_w && lat_a == 6'h1b |-> cfg_rdata == 32'h0000_0001)
    else $error("capability header wrong");
endmodule

// file: tb/lcs_link_regs_bench.sv
// self-checking bench for the link register slice
// assumes lcs_link_regs with its checker bound below
`timescale 1ns/10ps
module lcs_link_regs_bench;
  logic clock = 1'b0;
  logic reset_n;
  logic cfg_valid = 1'b0;
  logic cfg_write = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_byte_en = 4'h0;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic [5:0] link_width_raw = 6'h00;
  logic cfg_ready;
  logic cfg_done;
  logic [31:0] cfg_rdata;
  logic common_clock_flag;
  logic [2:0] idle_exit_latency;
  logic [5:0] negotiated_lane_width;
  int err_total = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h0000_95a2;
  logic m_flag = 1'b0;
  logic [1:0] m_pm = 2'h0;
  logic [5:0] m_w = 6'h00;
  logic [7:0] addr_tab [5] = '{8'h50, 8'h54, 8'h56, 8'h6c, 8'h80};
  logic [5:0] width_tab [3] = '{6'h00, 6'h04, 6'h08};

  always #12.5 clock = ~clock;

  lcs_link_regs lcs_link_regs_i (
    .clock(clock),
    .reset_n(reset_n),
    .cfg_valid(cfg_valid),
    .cfg_write(cfg_write),
    .cfg_addr(cfg_addr),
    .cfg_byte_en(cfg_byte_en),
    .cfg_wdata(cfg_wdata),
    .cfg_ready(cfg_ready),
    .cfg_done(cfg_done),
    .cfg_rdata(cfg_rdata),
    .link_width_raw(link_width_raw),
    .common_clock_flag(common_clock_flag),
    .idle_exit_latency(idle_exit_latency),
    .negotiated_lane_width(negotiated_lane_width)
  );

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction

  // ********************
  // behavioural register model
  // ********************
  function automatic logic [31:0] model_rd(input logic [7:0] a);
    case (a[7:2])
      6'h14: model_rd = {17'h0_0007, m_flag ? 3'h2 : 3'h6, 12'h081};
      6'h15: model_rd = {6'h00, m_w, 4'h1, 9'h000, m_flag, 4'h0, m_pm};
      6'h1b: model_rd = 32'h0000_0001;
      default: model_rd = 32'h0000_0000;
    endcase
  endfunction

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_port(input logic [7:0] got, input logic [7:0] exp);
    cmp_word({24'h00_0000, got}, {24'h00_0000, exp});
  endtask

  task automatic check_ports();
    cmp_port({7'h00, common_clock_flag}, {7'h00, m_flag});
    cmp_port({5'h00, idle_exit_latency}, {5'h00, m_flag ? 3'h2 : 3'h6});
    cmp_port({2'h0, negotiated_lane_width}, {2'h0, m_w});
  endtask

  task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    int n;
    logic r;
    @(posedge clock);
    cfg_valid <= 1'b1;
    cfg_write <= w;
    cfg_addr <= a;
    cfg_byte_en <= be;
    cfg_wdata <= d;
    n = 0;
    r = 1'b0;
    while (r !== 1'b1 && n < 20) begin
      @(negedge clock);
      r = cfg_ready;
      @(posedge clock);
      n++;
    end
    cfg_valid <= 1'b0;
    repeat (2) @(negedge clock);
    cmp_port({7'h00, cfg_done}, 8'h01);
    if (w && be[0] && a[7:2] == 6'h15) begin
      m_flag = d[6];
      m_pm = d[1:0];
    end
    cmp_word(cfg_rdata, w ? 32'h0000_0000 : model_rd(a));
    check_ports();
  endtask

  initial begin
    #50000;
    err_total++;
    end_of_test();
  end

  initial begin
    // edge at time zero so every flop is defined before the first clock
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    check_ports();
    foreach (addr_tab[i]) access(1'b0, addr_tab[i], 4'hf, 32'h0000_0000);
    foreach (width_tab[i]) begin
      @(posedge clock);
      link_width_raw <= width_tab[i];
      m_w = width_tab[i];
      repeat (3) @(posedge clock);
      access(1'b0, 8'h56, 4'hc, 32'h0000_0000);
    end
    for (int c = 0; c < 8; c++) begin
      seed = xorshift(seed);
      access(1'b1, 8'h54, 4'h1, (seed & 32'hffff_ffbc) | (c[2] << 6) | c[1:0]);
      access(1'b0, 8'h54, 4'hf, seed);
      access(1'b0, 8'h50, 4'hf, seed);
    end
    for (int k = 0; k < 12; k++) begin
      seed = xorshift(seed);
      access(1'b1, addr_tab[seed % 5], seed[7:4], xorshift(seed));
      access(1'b0, 8'h54, 4'hf, 32'h0000_0000);
    end
    access(1'b1, 8'h54, 4'h1, 32'h0000_0043);
    @(posedge clock);
    reset_n <= 1'b0;
    m_flag = 1'b0;
    m_pm = 2'h0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    access(1'b0, 8'h54, 4'hf, 32'h0000_0000);
    end_of_test();
  end
endmodule

bind lcs_link_regs lcs_link_regs_asserts lcs_link_regs_asserts_i (
  .clock(clock),
  .reset_n(reset_n),
  .cfg_valid(cfg_valid),
  .cfg_write(cfg_write),
  .cfg_addr(cfg_addr),
  .cfg_byte_en(cfg_byte_en),
  .cfg_wdata(cfg_wdata),
  .cfg_ready(cfg_ready),
  .cfg_done(cfg_done),
  .cfg_rdata(cfg_rdata),
  .link_width_raw(link_width_raw),
  .common_clock_flag(common_clock_flag),
  .idle_exit_latency(idle_exit_latency),
  .negotiated_lane_width(negotiated_lane_width)
);
